// [rtl/pif_flag_block.sv]
/*
 * Two 8-bit peripheral interrupt flag registers with their enables,
 * a control register and one level interrupt request, behind a
 * classic Wishbone slave.
 * Assumes event inputs are one-cycle pulses synchronous to clk, except
 * the serial receive and transmit sources, which are levels.
 */
// Local design decisions: the register addresses and register access over Wishbone.
`include "pif_regs.svh"

`default_nettype none

// What this block does
// R1: A flag is set by its source event whatever its enable bits hold.
// R2: Software should clear a stale flag before enabling its interrupt.
// R3: All implemented flag bits reset to zero on any reset.
// R4: A flag reads one while its interrupt is pending, zero otherwise.
// R5: Timer1 gate sits at bit 7 and converter done at bit 6, both R/W.
// R6: Serial receive at bit 5 and transmit at bit 4 are read only.
// R7: Sync serial port at bit 3 and capture/compare 1 at bit 2, R/W.
// R8: Timer2 match at bit 1 and timer1 overflow at bit 0, both R/W.
// R9: Second register holds bits 7,6,5,4,3 and 0 as R/W flags.
// R10: Bits 2 and 1 of the second register read zero and ignore writes.
// R11: No flag interrupts unless the peripheral enable bit is set.
// R12: The request rises when a flag and its enable meet both enables.
module pif_flag_block
   import pif_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic timer1_gate_evt,
   input wire logic adc_done_evt,
   input wire logic serial_rx_level,
   input wire logic serial_tx_level,
   input wire logic sync_serial_evt,
   input wire logic capcomp_one_evt,
   input wire logic timer2_match_evt,
   input wire logic timer1_overflow_evt,
   input wire logic osc_fail_evt,
   input wire logic comparator_two_evt,
   input wire logic comparator_one_evt,
   input wire logic eeprom_write_done_evt,
   input wire logic bus_collision_evt,
   input wire logic capcomp_two_evt,
   output logic periph_irq
);

   initial begin
      if (ADDR_W < 5 || ADDR_W > 32) begin
         $error("pif_flag_block: ADDR_W must lie in 5..32");
      end
   end

   pif_byte_t periph_irq_flags_a_q;
   pif_byte_t periph_irq_flags_a_d;
   pif_byte_t periph_irq_flags_b_q;
   pif_byte_t periph_irq_flags_b_d;
   pif_byte_t en_a_q;
   pif_byte_t en_a_d;
   pif_byte_t en_b_q;
   pif_byte_t en_b_d;
   pif_byte_t irq_control_reg_q;
   pif_byte_t irq_control_reg_d;
   logic ack_q;
   logic [31:0] rdata_q;
   logic irq_q;

   // bus decode
   wire logic req = wb_cyc_i & wb_stb_i;
   wire logic [7:0] adr8 = 8'(wb_adr_i);
   wire logic hi_zero = (wb_adr_i >> 8) == '0;
   wire logic lane0 = wb_sel_i[0];
   // a write lands on the edge where the master sees ack
   wire logic wr_fire = req & wb_we_i & ack_q & lane0;
   pif_sel_t sel;
   assign sel = !hi_zero ? PIF_SEL_NONE :
      (adr8 == `PIF_OFS_FLAGS_A) ? PIF_SEL_FLAGS_A :
      (adr8 == `PIF_OFS_FLAGS_B) ? PIF_SEL_FLAGS_B :
      (adr8 == `PIF_OFS_EN_A) ? PIF_SEL_EN_A :
      (adr8 == `PIF_OFS_EN_B) ? PIF_SEL_EN_B :
      (adr8 == `PIF_OFS_CTRL) ? PIF_SEL_CTRL :
      (adr8 == `PIF_OFS_CLR_A) ? PIF_SEL_CLR_A :
      (adr8 == `PIF_OFS_CLR_B) ? PIF_SEL_CLR_B : PIF_SEL_NONE;
   wire pif_byte_t wbyte = wb_dat_i[7:0];
   wire logic wr_flags_a = wr_fire & (sel == PIF_SEL_FLAGS_A);
   wire logic wr_flags_b = wr_fire & (sel == PIF_SEL_FLAGS_B);
   wire logic wr_en_a = wr_fire & (sel == PIF_SEL_EN_A);
   wire logic wr_en_b = wr_fire & (sel == PIF_SEL_EN_B);
   wire logic wr_ctrl = wr_fire & (sel == PIF_SEL_CTRL);
   wire logic wr_clr_a = wr_fire & (sel == PIF_SEL_CLR_A);
   wire logic wr_clr_b = wr_fire & (sel == PIF_SEL_CLR_B);

   // event vectors, gathered without looking at any enable
   pif_byte_t evt_a;
   pif_byte_t evt_b;
   pif_byte_t lvl_a;
   always_comb begin
      evt_a = `PIF_RST_BYTE;
      evt_a[`PIF_A_TMR1_GATE] = timer1_gate_evt; // R5
      evt_a[`PIF_A_ADC_DONE] = adc_done_evt; // R5
      evt_a[`PIF_A_SYNC_SER] = sync_serial_evt; // R7
      evt_a[`PIF_A_CAPCOMP1] = capcomp_one_evt; // R7
      evt_a[`PIF_A_TMR2_MATCH] = timer2_match_evt; // R8
      evt_a[`PIF_A_TMR1_OVF] = timer1_overflow_evt; // R8
      lvl_a = `PIF_RST_BYTE;
      lvl_a[`PIF_A_SER_RX] = serial_rx_level; // R6
      lvl_a[`PIF_A_SER_TX] = serial_tx_level; // R6
      evt_b = `PIF_RST_BYTE;
      evt_b[`PIF_B_OSC_FAIL] = osc_fail_evt; // R9
      evt_b[`PIF_B_CMP_TWO] = comparator_two_evt; // R9
      evt_b[`PIF_B_CMP_ONE] = comparator_one_evt; // R9
      evt_b[`PIF_B_EE_DONE] = eeprom_write_done_evt; // R9
      evt_b[`PIF_B_BUS_COLL] = bus_collision_evt; // R9
      evt_b[`PIF_B_CAPCOMP2] = capcomp_two_evt; // R9
   end

   // flag next state: software value first, then events on top so a
   // set in the same cycle as a clear is never lost
   pif_byte_t keep_a;
   pif_byte_t keep_b;
   assign keep_a = wr_flags_a ?
      ((periph_irq_flags_a_q & ~`PIF_A_WRITABLE) |
       (wbyte & `PIF_A_WRITABLE)) :
      wr_clr_a ? (periph_irq_flags_a_q & ~(wbyte & `PIF_A_WRITABLE)) :
      periph_irq_flags_a_q;
   assign keep_b = wr_flags_b ? (wbyte & `PIF_B_WRITABLE) :
      wr_clr_b ? (periph_irq_flags_b_q & ~(wbyte & `PIF_B_WRITABLE)) :
      periph_irq_flags_b_q;
   // read-only bits simply mirror their source levels
   assign periph_irq_flags_a_d =
      (((keep_a | evt_a) & `PIF_A_WRITABLE) | lvl_a) & `PIF_A_IMPL; // R1
   assign periph_irq_flags_b_d =
      (keep_b | evt_b) & `PIF_B_IMPL; // R1 R10

   assign en_a_d = wr_en_a ? (wbyte & `PIF_A_IMPL) : en_a_q;
   assign en_b_d = wr_en_b ? (wbyte & `PIF_B_IMPL) : en_b_q;
   assign irq_control_reg_d = wr_ctrl ? (wbyte & `PIF_CTRL_IMPL) :
      irq_control_reg_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         periph_irq_flags_a_q <= `PIF_RST_BYTE; // R3
         periph_irq_flags_b_q <= `PIF_RST_BYTE; // R3
         en_a_q <= `PIF_RST_BYTE;
         en_b_q <= `PIF_RST_BYTE;
         irq_control_reg_q <= `PIF_RST_BYTE;
      end else begin
         periph_irq_flags_a_q <= periph_irq_flags_a_d;
         periph_irq_flags_b_q <= periph_irq_flags_b_d;
         en_a_q <= en_a_d;
         en_b_q <= en_b_d;
         irq_control_reg_q <= irq_control_reg_d;
      end
   end

   // request: a pending enabled flag gated by both global enables;
   // software is expected to clear stale flags before enabling
   wire logic any_a = |(periph_irq_flags_a_q & en_a_q); // R12 R2
   wire logic any_b = |(periph_irq_flags_b_q & en_b_q); // R12
   wire logic periph_on = irq_control_reg_q[`PIF_CTRL_PERIPH_EN]; // R11
   wire logic global_on = irq_control_reg_q[`PIF_CTRL_GLOBAL_EN];
   wire logic irq_d = (any_a | any_b) & periph_on & global_on; // R11 R12

   // read mux; unmapped and flag-clear aliases read zero
   pif_byte_t rbyte;
   always_comb begin
      case (sel)
         PIF_SEL_FLAGS_A: rbyte = periph_irq_flags_a_q; // R4
         PIF_SEL_FLAGS_B: rbyte = periph_irq_flags_b_q; // R4 R10
         PIF_SEL_EN_A: rbyte = en_a_q;
         PIF_SEL_EN_B: rbyte = en_b_q;
         PIF_SEL_CTRL: rbyte = irq_control_reg_q;
         default: rbyte = `PIF_RST_BYTE;
      endcase
   end

   // one wait state: ack one edge after the request, then drop
   always_ff @(posedge clk) begin
      if (srst) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         irq_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
         rdata_q <= {24'h00_0000, rbyte};
         irq_q <= irq_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;
   assign periph_irq = irq_q;

endmodule : pif_flag_block

`default_nettype wire

// [rtl/pif_regs.svh]
/*
 * Offsets, bit positions and reset values of the peripheral flag block.
 * Assumes a 32-bit classic Wishbone slave, one register to a word.
 */
`ifndef PIF_REGS_SVH
`define PIF_REGS_SVH

`define PIF_OFS_FLAGS_A 8'h00
`define PIF_OFS_FLAGS_B 8'h04
`define PIF_OFS_EN_A 8'h08
`define PIF_OFS_EN_B 8'h0C
`define PIF_OFS_CTRL 8'h10
`define PIF_OFS_CLR_A 8'h14
`define PIF_OFS_CLR_B 8'h18

// first flag register
`define PIF_A_TMR1_GATE 7
`define PIF_A_ADC_DONE 6
`define PIF_A_SER_RX 5
`define PIF_A_SER_TX 4
`define PIF_A_SYNC_SER 3
`define PIF_A_CAPCOMP1 2
`define PIF_A_TMR2_MATCH 1
`define PIF_A_TMR1_OVF 0

// second flag register
`define PIF_B_OSC_FAIL 7
`define PIF_B_CMP_TWO 6
`define PIF_B_CMP_ONE 5
`define PIF_B_EE_DONE 4
`define PIF_B_BUS_COLL 3
`define PIF_B_CAPCOMP2 0

// control register
`define PIF_CTRL_GLOBAL_EN 7
`define PIF_CTRL_PERIPH_EN 6

// implemented and software-writable bits
`define PIF_A_IMPL 8'hFF
`define PIF_A_WRITABLE 8'hCF
`define PIF_B_IMPL 8'hF9
`define PIF_B_WRITABLE 8'hF9
`define PIF_CTRL_IMPL 8'hC0

`define PIF_RST_BYTE 8'h00

`endif

// [rtl/pif_pkg.sv]
/*
 * Types shared by the peripheral flag block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package pif_pkg;

   typedef logic [7:0] pif_byte_t;

   typedef enum logic [2:0] {
      PIF_SEL_FLAGS_A = 3'h0,
      PIF_SEL_FLAGS_B = 3'h1,
      PIF_SEL_EN_A = 3'h2,
      PIF_SEL_EN_B = 3'h3,
      PIF_SEL_CTRL = 3'h4,
      PIF_SEL_CLR_A = 3'h5,
      PIF_SEL_CLR_B = 3'h6,
      PIF_SEL_NONE = 3'h7
   } pif_sel_t;

endpackage : pif_pkg

`default_nettype wire

// [dv/pif_flag_block_checker.sv]
/* port assertions for pif_flag_block, bound into every instance;
   assumes the one-cycle registered ack and registered read data */
`default_nettype none
module pif_flag_block_checker #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic serial_rx_level,
   input wire logic serial_tx_level,
   input wire logic periph_irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_rd(int a);
      wb_ack_o && !wb_we_i && wb_adr_i == a;
   endsequence
   a_ack_follows_req: assert property (
      s_req |=> wb_ack_o) else $error("ack missing");
   a_ack_one_pulse: assert property (
      wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   a_ack_has_req: assert property (
      wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
   a_dat_high_zero: assert property (
      wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper data");
   a_serial_mirror: assert property (
      s_rd(0) |-> wb_dat_o[5:4] == {$past(serial_rx_level, 2),
      $past(serial_tx_level, 2)}) else $error("serial flags");
   a_b_gap_zero: assert property (
      s_rd(4) |-> wb_dat_o[2:1] == 2'h0) else $error("gap bits");
   a_reset_clears: assert property (disable iff (1'b0)
      srst |=> !wb_ack_o && !periph_irq && wb_dat_o == 32'h0)
      else $error("reset state");
   // flags and enables only fall through reset, writes or the serial levels
   // the irq flop trails the flags, which trail their causes, by one edge each; the check samples causes one back
   a_irq_fall_cause: assert property (
      $fell(periph_irq) |-> $past(srst) || $past(wb_we_i) &&
      $past(wb_ack_o) || !$past(serial_rx_level) ||
      !$past(serial_tx_level)) else $error("irq fell");
endmodule : pif_flag_block_checker
bind pif_flag_block pif_flag_block_checker #(.ADDR_W(ADDR_W)) chk (.*);
`default_nettype wire

// [dv/pif_src_model.sv]
/* far side of pif_flag_block: peripherals raising set pulses and the
   serial levels; assumes fire changes just after clk edges */
`default_nettype none
module pif_src_model (
   input wire logic clk,
   input wire logic [13:0] fire,
   output logic [13:0] ev = 14'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   // a real source drives after its own edge; one cycle of delay keeps
   // pulses aligned the way the block will see them
   always @(posedge clk) begin
      ev <= fire;
   end
endmodule : pif_src_model
`default_nettype wire

// [dv/tb_pif_flag_block.sv]
/* bench for pif_flag_block: register model compared at every read
   and irq check; assumes the source model and the bound checker */
`default_nettype none
module tb_pif_flag_block;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, periph_irq;
   logic timer1_gate_evt, adc_done_evt, sync_serial_evt, capcomp_one_evt;
   logic timer2_match_evt, timer1_overflow_evt, osc_fail_evt;
   logic comparator_two_evt, comparator_one_evt, eeprom_write_done_evt;
   logic bus_collision_evt, capcomp_two_evt, serial_rx_level;
   logic serial_tx_level;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd, seed;
   logic [13:0] fire, ev;
   int mismatches, check_count, cycles;
   int m[5];
   assign {serial_rx_level, serial_tx_level, timer1_gate_evt,
      adc_done_evt, sync_serial_evt, capcomp_one_evt, timer2_match_evt,
      timer1_overflow_evt, osc_fail_evt, comparator_two_evt,
      comparator_one_evt, eeprom_write_done_evt, bus_collision_evt,
      capcomp_two_evt} = ev;
   pif_flag_block DUT (.*);
   pif_src_model src (.clk(clk), .fire(fire), .ev(ev));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction : xs
   function automatic logic ei();
      logic [7:0] a;
      a = 8'(m[0]) | {fire[13:12], 4'h0};
      return m[4][7] & m[4][6] & |(a & 8'(m[2]) | 8'(m[1] & m[3]));
   endfunction : ei
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input int i, input logic [7:0] d);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
      wb_adr_i <= 8'(i * 4);
      wb_dat_i <= {24'h0, d};
      // only the cycle ceiling ends a wait for ack
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      @(posedge clk);
   endtask : bus
   task automatic wr(input int i, input logic [7:0] d);
      bus(1'b1, i, d);
      // a write with the low byte lane off must leave everything alone
      if (wb_sel_i[0]) case (i)
         0: m[0] = d & 8'hCF;
         1: m[1] = d & 8'hF9;
         2: m[2] = d;
         3: m[3] = d & 8'hF9;
         4: m[4] = d & 8'hC0;
         5: m[0] &= ~d;
         6: m[1] &= ~d;
         default: ;
      endcase
   endtask : wr
   task automatic rdchk(input int i);
      bus(1'b0, i, 8'h00);
      chk(rd, i < 5 ? m[i] | (i == 0 ? fire[13:12] << 4 : 0) : 0);
   endtask : rdchk
   task automatic irqchk;
      @(posedge clk);
      chk(32'(periph_irq), 32'(ei()));
   endtask : irqchk
   task automatic pulse(input logic [11:0] e);
      fire[11:0] <= e;
      @(posedge clk);
      fire[11:0] <= 12'h0;
      repeat (3) @(posedge clk);
      m[0] |= {e[11:10], 2'h0, e[9:6]};
      m[1] |= {e[5:2], e[1], 2'h0, e[0]};
   endtask : pulse
   always @(posedge clk) begin
      cycles++;
      if (cycles == 12000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   initial begin
      srst = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      fire = 14'h0;
      seed = 32'h22;
      m = '{default: 0};
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 8; i++) rdchk(i);
      for (int i = 0; i < 5; i++) wr(i, 8'hFF);
      for (int i = 0; i < 8; i++) rdchk(i);
      irqchk();
      wr(5, 8'hFF);
      wr(6, 8'hFF);
      irqchk();
      wr(4, 8'h40);
      for (int k = 0; k < 12; k++) pulse(12'h1 << k);
      rdchk(0);
      rdchk(1);
      irqchk();
      fire[13:12] <= 2'h3;
      wr(0, 8'h00);
      rdchk(0);
      wr(5, 8'hFF);
      wr(6, 8'hFF);
      repeat (200) begin
         seed = xs(seed);
         fire[13:12] <= seed[13:12];
         pulse(seed[11:0]);
         wb_sel_i <= {3'h7, seed[14]};
         wr(seed[20:18], seed[31:24]);
         rdchk(seed[23:21]);
         irqchk();
      end
      // gate event reaches the block on the very edge its clear lands
      wb_sel_i <= 4'hF;
      fire[11:0] <= 12'h800;
      fork
         wr(5, 8'h80);
         begin
            @(posedge clk);
            fire[11:0] <= 12'h000;
         end
      join
      m[0] |= 8'h80;
      rdchk(0);
      // second reset in mid-run
      srst <= 1'b1;
      fire[13:12] <= 2'h0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      m = '{default: 0};
      for (int i = 0; i < 8; i++) rdchk(i);
      irqchk();
      tally_and_finish();
   end
endmodule : tb_pif_flag_block
`default_nettype wire
